// File: src/loop_status_defines.vh
// Offsets, field positions and reset values of the loop status registers
`ifndef LOOP_STATUS_DEFINES_VH
`define LOOP_STATUS_DEFINES_VH

`define ADDR_W              9
`define OFF_LIVE_1          9'h056
`define OFF_LIVE_2          9'h057
`define OFF_LATCH_1         9'h059
`define OFF_LATCH_2         9'h05a
`define OFF_IRQ_EN_1        9'h05b
`define OFF_IRQ_EN_2        9'h05c
`define OFF_TUNE_B0         9'h065
`define OFF_TUNE_B1         9'h066
`define OFF_TUNE_B2         9'h067
`define OFF_TUNE_B3         9'h068
`define OFF_PHASE_B0        9'h07d
`define OFF_PHASE_B1        9'h07e
`define OFF_PHASE_B2        9'h07f
`define OFF_PHASE_B3        9'h080

`define BIT_LOCK_LOSS       5
`define BIT_TRACKING        4
`define BIT_HOLDOVER        3
`define BIT_LIMIT_HIT       2

`define RST_BYTE            8'h00
`define RST_WORD            32'h00000000

`endif

// File: src/byte_snapshot.v
// Coherent 32-bit snapshot of a four-byte read-only field
module byte_snapshot #(
    parameter WIDTH = 32                   // Field width
) (
    input  wire             clk,           // System clock
    input  wire             rst,           // Sync reset, active high
    input  wire [WIDTH-1:0] live,          // Live field value
    input  wire             capture,       // Pulse: take a new snapshot
    input  wire [1:0]       sel,           // Byte lane to present
    output wire [7:0]       rd_byte        // Selected byte
);
`include "loop_status_defines.vh"

    reg [WIDTH-1:0] snap_q;                // Held field image

    // Take a copy of the whole field when the lowest byte is read
    always @(posedge clk) begin
        if (rst) begin
            snap_q <= `RST_WORD;
        end else if (capture) begin
            snap_q <= live;
        end
    end

    // Low byte reads straight through so it matches the snapshot taken
    assign rd_byte = capture ? live[7:0] : snap_q[sel*8 +: 8];

endmodule // byte_snapshot

// File: src/dpll_status_irq_and_readout.v
// Loop status flags, interrupt enables, summary and offset/phase readout
`include "loop_status_defines.vh"
module dpll_status_irq_and_readout (
    input  wire                 clk,             // System clock 25 MHz
    input  wire                 rst,             // Sync reset, active high
    input  wire [`ADDR_W-1:0]   addr,            // Register address
    input  wire                 wr_en,           // Write strobe, one cycle
    input  wire [7:0]           wr_data,         // Write data
    input  wire                 rd_en,           // Read strobe, one cycle
    output reg  [7:0]           rd_data,         // Read data, registered
    input  wire                 lock_loss_live,  // Live loss of lock
    input  wire                 tracking_live,   // Live tracking state
    input  wire                 holdover_live,   // Live digital hold state
    input  wire                 limit_hit_live,  // Live frequency limited
    input  wire [31:0]          tuning_offset,   // Signed tuning offset
    input  wire [31:0]          phase_value,     // Signed phase detector
    output wire                 loop_irq_summary // Enabled flag summary
);

    // Enable registers
    reg        lock_loss_irq_enable_q;   // Lock-loss enable
    reg        tracking_irq_enable_q;    // Tracking enable
    reg        holdover_irq_enable_q;    // Holdover enable
    reg        limit_hit_irq_enable_q;   // Limit-hit enable

    // Latched change flags
    reg        lock_loss_change_flag_q;  // Lock-loss changed
    reg        tracking_change_flag_q;   // Tracking changed
    reg        holdover_change_flag_q;   // Holdover changed
    reg        limit_hit_change_flag_q;  // Limit-hit changed

    // Previous live levels for change detection
    reg  [3:0] live_prev_q;              // Live bits one cycle ago
    reg        prev_valid_q;             // Previous levels are meaningful

    wire [3:0] live_now;                 // Live bits this cycle
    wire [3:0] changed;                  // Change events
    wire       wr_latch_1;               // Write to latched register 1
    wire       wr_latch_2;               // Write to latched register 2
    wire [7:0] tune_byte;                // Tuning snapshot byte
    wire [7:0] phase_byte;               // Phase snapshot byte
    wire       tune_cap;                 // Low tuning byte read
    wire       phase_cap;                // Low phase byte read

    // Returns the next value of a write-1-to-clear flag; set wins
    function next_flag;
        input cur;
        input set;
        input clr;
        begin
            next_flag = set | (cur & ~clr);
        end
    endfunction

    assign live_now = {limit_hit_live, lock_loss_live,
                       tracking_live, holdover_live};
    assign changed  = prev_valid_q ? (live_now ^ live_prev_q) : 4'h0;

    assign wr_latch_1 = wr_en && (addr == `OFF_LATCH_1);
    assign wr_latch_2 = wr_en && (addr == `OFF_LATCH_2);

    // Track live levels; first cycle after reset only primes them
    always @(posedge clk) begin
        if (rst) begin
            live_prev_q  <= 4'h0;
            prev_valid_q <= 1'b0;
        end else begin
            live_prev_q  <= live_now;
            prev_valid_q <= 1'b1;
        end
    end

    // Latched flags: set on live change, cleared by writing 1
    always @(posedge clk) begin
        if (rst) begin
            lock_loss_change_flag_q <= 1'b0;
            tracking_change_flag_q  <= 1'b0;
            holdover_change_flag_q  <= 1'b0;
            limit_hit_change_flag_q <= 1'b0;
        end else begin
            lock_loss_change_flag_q <= next_flag(lock_loss_change_flag_q,
                changed[2], wr_latch_1 & wr_data[`BIT_LOCK_LOSS]);
            tracking_change_flag_q  <= next_flag(tracking_change_flag_q,
                changed[1], wr_latch_1 & wr_data[`BIT_TRACKING]);
            holdover_change_flag_q  <= next_flag(holdover_change_flag_q,
                changed[0], wr_latch_1 & wr_data[`BIT_HOLDOVER]);
            limit_hit_change_flag_q <= next_flag(limit_hit_change_flag_q,
                changed[3], wr_latch_2 & wr_data[`BIT_LIMIT_HIT]);
        end
    end

    // Enable register writes
    always @(posedge clk) begin
        if (rst) begin
            lock_loss_irq_enable_q <= 1'b0;
            tracking_irq_enable_q  <= 1'b0;
            holdover_irq_enable_q  <= 1'b0;
            limit_hit_irq_enable_q <= 1'b0;
        end else if (wr_en) begin
            if (addr == `OFF_IRQ_EN_1) begin
                lock_loss_irq_enable_q <= wr_data[`BIT_LOCK_LOSS];
                tracking_irq_enable_q  <= wr_data[`BIT_TRACKING];
                holdover_irq_enable_q  <= wr_data[`BIT_HOLDOVER];
            end
            if (addr == `OFF_IRQ_EN_2) begin
                limit_hit_irq_enable_q <= wr_data[`BIT_LIMIT_HIT];
            end
        end
    end

    // Summary of enabled flags
    assign loop_irq_summary =
          (lock_loss_change_flag_q & lock_loss_irq_enable_q)
        | (tracking_change_flag_q  & tracking_irq_enable_q)
        | (holdover_change_flag_q  & holdover_irq_enable_q)
        | (limit_hit_change_flag_q & limit_hit_irq_enable_q);

    // Snapshot strobes on low-byte reads
    assign tune_cap  = rd_en && (addr == `OFF_TUNE_B0);
    assign phase_cap = rd_en && (addr == `OFF_PHASE_B0);

    // Tuning offset readout, signed, read-only
    byte_snapshot #(
        .WIDTH   (32)
    ) u_tune_snap (
        .clk     (clk),
        .rst     (rst),
        .live    (tuning_offset),
        .capture (tune_cap),
        .sel     (addr[1:0] - 2'd1),
        .rd_byte (tune_byte)
    );

    // Phase detector readout, signed, read-only
    byte_snapshot #(
        .WIDTH   (32)
    ) u_phase_snap (
        .clk     (clk),
        .rst     (rst),
        .live    (phase_value),
        .capture (phase_cap),
        .sel     (addr[1:0] - 2'd1),
        .rd_byte (phase_byte)
    );

    // Registered read mux; unmapped addresses and reserved bits read 0
    always @(posedge clk) begin
        if (rst) begin
            rd_data <= `RST_BYTE;
        end else if (rd_en) begin
            case (addr)
                `OFF_LIVE_1: begin
                    rd_data <= {2'b00, lock_loss_live, tracking_live,
                                holdover_live, 3'b000};
                end
                `OFF_LIVE_2: begin
                    rd_data <= {5'b00000, limit_hit_live, 2'b00};
                end
                `OFF_LATCH_1: begin
                    rd_data <= {2'b00, lock_loss_change_flag_q,
                                tracking_change_flag_q,
                                holdover_change_flag_q, 3'b000};
                end
                `OFF_LATCH_2: begin
                    rd_data <= {5'b00000, limit_hit_change_flag_q, 2'b00};
                end
                `OFF_IRQ_EN_1: begin
                    rd_data <= {2'b00, lock_loss_irq_enable_q,
                                tracking_irq_enable_q,
                                holdover_irq_enable_q, 3'b000};
                end
                `OFF_IRQ_EN_2: begin
                    rd_data <= {5'b00000, limit_hit_irq_enable_q, 2'b00};
                end
                `OFF_TUNE_B0, `OFF_TUNE_B1,
                `OFF_TUNE_B2, `OFF_TUNE_B3: begin
                    rd_data <= tune_byte;
                end
                `OFF_PHASE_B0, `OFF_PHASE_B1,
                `OFF_PHASE_B2, `OFF_PHASE_B3: begin
                    rd_data <= phase_byte;
                end
                default: begin
                    rd_data <= `RST_BYTE;
                end
            endcase
        end
    end

endmodule // dpll_status_irq_and_readout

// File: verif/dpll_status_irq_and_readout_chk.sv
// Port assertions for the loop status block
`include "loop_status_defines.vh"
module dpll_status_chk (
    input wire               clk,            // Clock
    input wire               rst,            // Reset
    input wire [`ADDR_W-1:0] addr,           // Address
    input wire               wr_en,          // Write strobe
    input wire [7:0]         wr_data,        // Write data
    input wire               rd_en,          // Read strobe
    input wire [7:0]         rd_data,        // Read data
    input wire               lock_loss_live, // Live lock loss
    input wire               tracking_live,  // Live tracking
    input wire               holdover_live,  // Live hold
    input wire               limit_hit_live, // Live limit
    input wire [31:0]        tuning_offset,  // Tuning offset
    input wire [31:0]        phase_value,    // Phase value
    input wire               loop_irq_summary // Summary
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [3:0] lv = {lock_loss_live, tracking_live, holdover_live,
                     limit_hit_live};    // Live bits
    reg  [3:0] lv1_q;                    // Live bits, past cycles
    reg  [3:0] lv2_q;
    reg  [3:0] lv3_q;
    reg  [2:0] en1_q;                    // Shadow of enables 5Bh
    reg        en2_q;                    // Shadow of enable 5Ch
    // Live history and enable shadows
    always @(posedge clk) begin
        lv1_q <= lv;
        lv2_q <= lv1_q;
        lv3_q <= lv2_q;
        if (rst) begin
            en1_q <= 3'h0;
            en2_q <= 1'b0;
        end else if (wr_en && addr == `OFF_IRQ_EN_1) begin
            en1_q <= wr_data[5:3];
        end else if (wr_en && addr == `OFF_IRQ_EN_2) begin
            en2_q <= wr_data[2];
        end
    end
    sequence s_toggle;
        !wr_en && lv != lv1_q && en1_q == 3'h7 && en2_q;
    endsequence
    sequence s_snap;
        rd_en && addr == `OFF_TUNE_B0 ##1 rd_en && addr == `OFF_TUNE_B1;
    endsequence
    chk_rd_hold: assert property (!rd_en |=> $stable(rd_data))
        else $error("rd_data moved without read");
    chk_rst_zero: assert property (disable iff (1'b0)
        rst |=> rd_data == 8'h00 && !loop_irq_summary)
        else $error("outputs not cleared by reset");
    chk_tune_low: assert property (rd_en && addr == `OFF_TUNE_B0
        |=> rd_data == $past(tuning_offset[7:0]))
        else $error("tuning low byte wrong");
    chk_phase_low: assert property (rd_en && addr == `OFF_PHASE_B0
        |=> rd_data == $past(phase_value[7:0]))
        else $error("phase low byte wrong");
    chk_unmapped_zero: assert property (rd_en && addr == 9'h100
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    chk_snap_next: assert property (s_snap
        |=> rd_data == $past(tuning_offset[15:8], 2))
        else $error("snapshot byte wrong");
    chk_irq_off: assert property (en1_q == 3'h0 && !en2_q
        |-> !loop_irq_summary) else $error("summary with all disabled");
    chk_irq_set: assert property (s_toggle ##1 !wr_en
        |=> loop_irq_summary) else $error("change did not raise summary");
    chk_irq_quiet: assert property (!$past(wr_en) && lv == lv1_q
        && lv1_q == lv2_q && lv2_q == lv3_q
        |-> $stable(loop_irq_summary)) else $error("summary moved alone");
endmodule // dpll_status_chk

bind dpll_status_irq_and_readout dpll_status_chk i_dpll_status_chk (
    .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data), .lock_loss_live(lock_loss_live),
    .tracking_live(tracking_live), .holdover_live(holdover_live),
    .limit_hit_live(limit_hit_live), .tuning_offset(tuning_offset),
    .phase_value(phase_value), .loop_irq_summary(loop_irq_summary));

// File: verif/dpll_status_irq_and_readout_tb_top.sv
// Self-checking bench for the loop status block
`include "loop_status_defines.vh"
module dpll_status_irq_and_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg        clk = 1'b0;            // Clock
    reg        rst = 1'b1;            // Reset
    reg  [8:0] addr = 9'h000;         // Address
    reg        wr_en = 1'b0;          // Write strobe
    reg  [7:0] wr_data = 8'h00;       // Write data
    reg        rd_en = 1'b0;          // Read strobe
    reg  [3:0] lv = 4'h0;             // Live bits, lock loss first
    reg [31:0] tune = 32'h0;          // Tuning offset input
    reg [31:0] phase = 32'h0;         // Phase input
    wire [7:0] rd_data;               // Read data
    wire       irq;                   // Summary
    int        err_count = 0;         // Mismatches
    int        n_tests = 0;           // Comparisons
    int        i;                     // Loop index
    dpll_status_irq_and_readout i_dpll_status_irq_and_readout (
        .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
        .lock_loss_live(lv[3]), .tracking_live(lv[2]),
        .holdover_live(lv[1]), .limit_hit_live(lv[0]),
        .tuning_offset(tune), .phase_value(phase),
        .loop_irq_summary(irq));
    // Clock generator
    initial begin
        forever #20 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Write, then one idle cycle
    task wr(input [8:0] a, input [7:0] d);
        rd_en = 1'b0;
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask
    // Read, strobe left high for back-to-back use
    task rd(input [8:0] a, input [7:0] e);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        check(rd_data, e, "rd_data");
    endtask
    task t_reset;
        rd(`OFF_IRQ_EN_1, 8'h00);
        rd(`OFF_IRQ_EN_2, 8'h00);
        rd(`OFF_LATCH_1, 8'h00);
        rd(`OFF_LATCH_2, 8'h00);
        rd(`OFF_TUNE_B1, 8'h00);
        rd(`OFF_PHASE_B3, 8'h00);
        rd_en = 1'b0;
        @(negedge clk);
        check(irq, 1'b0, "summary");
        $display("t_reset done");
    endtask
    task t_irq;
        reg [7:0] b;
        reg [8:0] fa;
        reg [8:0] ea;
        for (i = 0; i < 4; i++) begin
            b = (i < 3) ? (8'h20 >> i) : 8'h04;
            fa = (i < 3) ? `OFF_LATCH_1 : `OFF_LATCH_2;
            ea = (i < 3) ? `OFF_IRQ_EN_1 : `OFF_IRQ_EN_2;
            wr(`OFF_IRQ_EN_1, 8'h38 & ~b);
            wr(`OFF_IRQ_EN_2, (i < 3) ? 8'h04 : 8'h00);
            lv[3-i] = ~lv[3-i];
            repeat (3) @(negedge clk);
            check(irq, 1'b0, "summary");
            rd(fa, b);
            wr(ea, (i < 3) ? 8'h38 : 8'h04);
            check(irq, 1'b1, "summary");
            wr(fa, ~b);
            check(irq, 1'b1, "summary");
            wr(fa, b);
            check(irq, 1'b0, "summary");
        end
        lv[3] = 1'b0;
        repeat (3) @(negedge clk);
        check(irq, 1'b1, "summary");
        rd(`OFF_LATCH_1, 8'h20);
        wr(`OFF_LATCH_1, 8'h20);
        check(irq, 1'b0, "summary");
        $display("t_irq done");
    endtask
    task t_read;
        tune = 32'h8123a5c7;
        phase = 32'hfedcba98;
        rd(`OFF_LIVE_1, 8'h18);
        rd(`OFF_LIVE_2, 8'h04);
        rd(`OFF_IRQ_EN_1, 8'h38);
        rd(`OFF_IRQ_EN_2, 8'h04);
        wr(`OFF_TUNE_B1, 8'h55);
        rd(`OFF_TUNE_B0, 8'hc7);
        tune = 32'h0;
        rd(`OFF_TUNE_B1, 8'ha5);
        rd(`OFF_TUNE_B2, 8'h23);
        rd(`OFF_TUNE_B3, 8'h81);
        rd(`OFF_PHASE_B0, 8'h98);
        phase = 32'h0;
        rd(`OFF_PHASE_B1, 8'hba);
        rd(`OFF_PHASE_B2, 8'hdc);
        rd(`OFF_PHASE_B3, 8'hfe);
        rd(9'h100, 8'h00);
        rd_en = 1'b0;
        @(negedge clk);
        $display("t_read done");
    endtask
    task results;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset;
        t_irq;
        t_read;
        results;
    end
    // Watchdog
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        results;
    end
endmodule // dpll_status_irq_and_readout_tb_top
